// file: rtl/ioh_hub.sv
// I/O hub core: PIO forwarding to the PCIe DMA unit, decode of the upper
// address byte to on-chip I/O units, and interrupt delivery to threads.
// Assumes valid/ready peers on one clock; routing table lives outside.
//
// Notes on behaviour
// - Accept writes with a 40-bit byte address
// - Byte mask passes to DMA unchanged
// - Store payload forwarded bit for bit
// - Write bus address has low three bits zero
// - All DMA-side interrupts are message-type
// - Only message interrupts wait for an answer; on-chip ones do not
// - Message interrupts answered in arrival order
// - Device id indexes the routing table
// - On-chip interrupts kept no record after delivery
// - Device ids 1 and 2 valid, rest reserved
// - Destination from address bits 39 to 32
// - Upper byte selects the on-chip unit
// - 0x84 picks memory controller by bits 13:12
// - L2 CSR range never reaches the hub
// - Four-bit credit tags, sixteen outstanding at most
// - Two-bit command space field to DMA
`timescale 1ns/1ns
module ioh_hub
  import ioh_pkg::*;
#(
  parameter int FIFO_DEPTH = IOH_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Requests from the cpu request crossbar
  input wire logic xbar_valid,
  output logic xbar_ready,
  input wire ioh_req_s xbar_req,
  // PIO requests to the PCIe DMA unit
  output logic dma_valid,
  input wire logic dma_ready,
  output ioh_dma_req_s dma_req,
  // Credit returns from the PCIe DMA unit
  input wire logic credit_ret_valid,
  input wire logic [IOH_CRED_W-1:0] credit_ret_id,
  // Packets to on-chip I/O units
  output logic io_valid,
  input wire logic io_ready,
  output ioh_io_req_s io_req,
  // Error completion to the requester
  output logic err_valid,
  output logic [7:0] err_pio_id,
  // Message interrupts from the system interface unit
  input wire logic mondo_valid,
  output logic mondo_ready,
  input wire ioh_route_s mondo_route,
  output logic mondo_ack,
  output logic mondo_nack,
  // On-chip interrupts and routing table lookup
  input wire logic onchip_valid,
  output logic onchip_ready,
  input wire logic [IOH_ID_W-1:0] onchip_dev_id,
  output logic [IOH_ID_W-1:0] route_idx,
  input wire ioh_route_s route_entry,
  // Interrupts to processor threads
  output logic irq_valid,
  input wire logic irq_ready,
  output ioh_irq_s irq,
  input wire logic irq_resp_valid,
  input wire logic irq_resp_ack
);
  initial
  begin
    if (FIFO_DEPTH < 2) $error("ioh_hub: FIFO_DEPTH too small");
  end

  // ==========================================================================
  // Main FIFO
  logic q_valid;
  logic q_ready;
  ioh_req_s q_req;

  ioh_fifo #(.WIDTH($bits(ioh_req_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(xbar_valid),
    .in_ready(xbar_ready),
    .in_data(xbar_req),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_req)
  );

  // ==========================================================================
  // Decode of the dequeued packet
  ioh_dest_e q_dest;
  logic [1:0] q_cmd;
  logic [IOH_BUS_ADDR_W-1:0] q_bus_addr;

  ioh_addr_decode u_dec (
    .req(q_req),
    .dest(q_dest),
    .cmd(q_cmd),
    .bus_addr(q_bus_addr)
  );

  // ==========================================================================
  // Credit pool
  logic [IOH_CRED_N-1:0] cred_free_ff;
  logic cred_any;
  logic [IOH_CRED_W-1:0] cred_pick;

  function automatic logic [IOH_CRED_W-1:0] lowest_set(input logic [IOH_CRED_N-1:0] v);
    logic [IOH_CRED_W-1:0] r;
    r = '0;
    for (int i = IOH_CRED_N - 1; i >= 0; i--)
      if (v[i]) r = IOH_CRED_W'(i);
    return r;
  endfunction

  assign cred_any = |cred_free_ff;
  assign cred_pick = lowest_set(cred_free_ff);

  // ==========================================================================
  // Dequeue steering
  logic to_dma;
  logic to_io;
  logic to_err;
  logic dma_load;
  logic io_load;

  assign to_dma = q_dest == IOH_DST_PIO;
  assign to_err = q_dest == IOH_DST_ERR;
  assign to_io = !to_dma && !to_err;
  // A PIO packet waits in the FIFO until both a credit and the output slot are free
  assign dma_load = q_valid && to_dma && cred_any && (!dma_valid || dma_ready);
  assign io_load = q_valid && to_io && (!io_valid || io_ready);
  assign q_ready = dma_load || io_load || (q_valid && to_err);

  // Allocation and return never name the same credit in one cycle
  always_ff @(posedge clk)
  begin
    if (srst)
      cred_free_ff <= '1;
    else
    begin
      for (int i = 0; i < IOH_CRED_N; i++)
      begin
        if (credit_ret_valid && credit_ret_id == IOH_CRED_W'(i))
          cred_free_ff[i] <= 1'b1;
        else if (dma_load && cred_pick == IOH_CRED_W'(i))
          cred_free_ff[i] <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // DMA output stage
  always_ff @(posedge clk)
  begin
    if (srst) dma_valid <= 1'b0;
    else if (dma_load) dma_valid <= 1'b1;
    else if (dma_ready) dma_valid <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      dma_req <= '0;
    else if (dma_load)
    begin
      dma_req.rd <= q_req.rd;
      dma_req.credit <= cred_pick;
      dma_req.mask <= q_req.mask;
      dma_req.pio_id <= q_req.pio_id;
      dma_req.cmd <= q_cmd;
      dma_req.bus_addr <= q_bus_addr;
      dma_req.data <= q_req.data;
    end
  end

  // ==========================================================================
  // On-chip unit output stage and error completion
  always_ff @(posedge clk)
  begin
    if (srst) io_valid <= 1'b0;
    else if (io_load) io_valid <= 1'b1;
    else if (io_ready) io_valid <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst) io_req <= '0;
    else if (io_load) io_req <= '{dest: q_dest, req: q_req};
  end

  always_ff @(posedge clk)
  begin
    if (srst) err_valid <= 1'b0;
    else err_valid <= q_valid && to_err;
  end

  always_ff @(posedge clk)
  begin
    if (srst) err_pio_id <= '0;
    else if (q_valid && to_err) err_pio_id <= q_req.pio_id;
  end

  // ==========================================================================
  // Interrupt delivery
  // One message interrupt in flight at a time keeps answers in sending order.
  typedef enum logic [1:0] {IOH_MS_IDLE, IOH_MS_SEND, IOH_MS_WAIT} ioh_mondo_e;
  ioh_mondo_e ms_ff;
  logic oc_pending_ff;
  logic irq_free;
  logic take_mondo;
  logic take_onchip;
  logic oc_known;

  assign route_idx = onchip_dev_id;
  assign oc_known = onchip_dev_id == IOH_DEV_MEM_ERR || onchip_dev_id == IOH_DEV_EXT_PIN;
  assign irq_free = !irq_valid || irq_ready;
  // Device and message interrupts share one output register; the mondo bit marks the kind, and a message wins the cycle
  assign take_mondo = mondo_valid && ms_ff == IOH_MS_IDLE && irq_free;
  assign take_onchip = onchip_valid && !take_mondo && irq_free;
  assign mondo_ready = take_mondo;
  // Reserved device ids are taken and dropped so they cannot block the port
  assign onchip_ready = take_onchip;

  always_ff @(posedge clk)
  begin
    if (srst)
      ms_ff <= IOH_MS_IDLE;
    else
    begin
      case (ms_ff)
        IOH_MS_IDLE: if (take_mondo) ms_ff <= IOH_MS_SEND;
        IOH_MS_SEND: if (irq_ready) ms_ff <= IOH_MS_WAIT;
        IOH_MS_WAIT: if (irq_resp_valid) ms_ff <= IOH_MS_IDLE;
        default: ms_ff <= IOH_MS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst) irq_valid <= 1'b0;
    else if (take_mondo || (take_onchip && oc_known)) irq_valid <= 1'b1;
    else if (irq_ready) irq_valid <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst) irq <= '0;
    else if (take_mondo) irq <= '{mondo: 1'b1, route: mondo_route};
    else if (take_onchip && oc_known) irq <= '{mondo: 1'b0, route: route_entry};
  end

  // Tracks only for checking that on-chip delivery leaves no trace
  always_ff @(posedge clk)
  begin
    if (srst) oc_pending_ff <= 1'b0;
    else oc_pending_ff <= irq_valid && irq_ready && !irq.mondo;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mondo_ack <= 1'b0;
      mondo_nack <= 1'b0;
    end
    else
    begin
      mondo_ack <= ms_ff == IOH_MS_WAIT && irq_resp_valid && irq_resp_ack;
      mondo_nack <= ms_ff == IOH_MS_WAIT && irq_resp_valid && !irq_resp_ack;
    end
  end

  // ==========================================================================
  // Checks
  wr_data_keep_a: assert property (@(posedge clk) disable iff (srst)
    dma_load |=> dma_req.data == $past(q_req.data) && dma_valid)
    else $error("store payload altered");

  wr_mask_pass_a: assert property (@(posedge clk) disable iff (srst)
    dma_load |=> dma_req.mask == $past(q_req.mask))
    else $error("byte mask altered");

  wr_addr_align_a: assert property (@(posedge clk) disable iff (srst)
    dma_load && !q_req.rd |=> dma_req.bus_addr[2:0] == 3'h0
      && dma_req.bus_addr[35:3] == $past(q_req.addr[35:3]))
    else $error("write bus address not aligned");

  dma_hold_a: assert property (@(posedge clk) disable iff (srst)
    dma_valid && !dma_ready |=> dma_valid && $stable(dma_req))
    else $error("DMA request changed before taken");

  io_hold_a: assert property (@(posedge clk) disable iff (srst)
    io_valid && !io_ready |=> io_valid && $stable(io_req))
    else $error("I/O request changed before taken");

  rsvd_dev_drop_a: assert property (@(posedge clk) disable iff (srst)
    take_onchip && !oc_known |=> !irq_valid)
    else $error("reserved device id delivered");

  credit_free_a: assert property (@(posedge clk) disable iff (srst)
    dma_load |-> cred_free_ff[cred_pick] ##1 !cred_free_ff[dma_req.credit]
      || (credit_ret_valid && credit_ret_id == dma_req.credit))
    else $error("credit reused while outstanding");

  cmd_space_a: assert property (@(posedge clk) disable iff (srst)
    dma_load && q_req.addr[35] |=> dma_req.cmd == IOH_CMD_MEM64)
    else $error("command space wrong");

  dest_decode_a: assert property (@(posedge clk) disable iff (srst)
    io_load |=> io_valid && io_req.dest == ioh_dest_of(io_req.req.addr))
    else $error("destination decode wrong");

  mc_select_a: assert property (@(posedge clk) disable iff (srst)
    io_load && q_req.addr[39:32] == IOH_UB_MEMCTL && q_req.addr[13:12] == 2'h3
      |=> io_req.dest == IOH_DST_MC3)
    else $error("memory controller select wrong");

  rsvd_err_a: assert property (@(posedge clk) disable iff (srst)
    q_valid && q_req.addr[39:32] == 8'h87 |-> !dma_load && !io_load ##1 err_valid)
    else $error("reserved address not refused");

  mondo_order_a: assert property (@(posedge clk) disable iff (srst)
    take_mondo |=> !mondo_ready until (mondo_ack || mondo_nack))
    else $error("second message interrupt taken early");

  onchip_forget_a: assert property (@(posedge clk) disable iff (srst)
    oc_pending_ff |-> ms_ff == $past(ms_ff) || ms_ff != IOH_MS_WAIT)
    else $error("on-chip delivery left state behind");

  cv_pio_write_c: cover property (@(posedge clk) disable iff (srst)
    dma_load && !q_req.rd ##1 dma_valid && dma_ready);
  cv_mondo_ack_c: cover property (@(posedge clk) disable iff (srst)
    take_mondo ##[1:20] mondo_ack);
  cv_mondo_nack_c: cover property (@(posedge clk) disable iff (srst)
    take_mondo ##[1:20] mondo_nack);
  cv_err_c: cover property (@(posedge clk) disable iff (srst) err_valid);
  cv_onchip_c: cover property (@(posedge clk) disable iff (srst)
    take_onchip && oc_known);
endmodule

// file: rtl/ioh_pkg.sv
// Shared constants, types and address decode for the I/O hub PIO write and
// interrupt block. Assumes a single core clock; nothing here holds state.
package ioh_pkg;

  // ==========================================================================
  // Widths and depths
  localparam int IOH_ADDR_W = 40;
  localparam int IOH_DATA_W = 64;
  localparam int IOH_MASK_W = 8;
  localparam int IOH_CRED_N = 16;
  localparam int IOH_CRED_W = 4;
  localparam int IOH_FIFO_DEPTH = 16;
  localparam int IOH_BUS_ADDR_W = 36;
  localparam int IOH_ID_W = 6;

  // ==========================================================================
  // Upper address byte map
  localparam logic [7:0] IOH_UB_HUB = 8'h80;
  localparam logic [7:0] IOH_UB_CLOCK = 8'h83;
  localparam logic [7:0] IOH_UB_MEMCTL = 8'h84;
  localparam logic [7:0] IOH_UB_TEST = 8'h85;
  localparam logic [7:0] IOH_UB_DEBUG = 8'h86;
  localparam logic [7:0] IOH_UB_DMA_CSR = 8'h88;
  localparam logic [7:0] IOH_UB_RESET = 8'h89;
  localparam logic [7:0] IOH_UB_SHARED = 8'h90;
  localparam logic [7:0] IOH_UB_BOOT = 8'hFF;
  localparam logic [7:0] IOH_UB_PIO_LO = 8'hC0;
  localparam logic [7:0] IOH_UB_PIO_HI = 8'hCF;
  localparam int IOH_MC_SEL_LSB = 12;
  localparam int IOH_IO_SEL_BIT = 28;

  // ==========================================================================
  // Command spaces and on-chip device identifiers
  localparam logic [1:0] IOH_CMD_MEM64 = 2'h3;
  localparam logic [1:0] IOH_CMD_MEM32 = 2'h2;
  localparam logic [1:0] IOH_CMD_IO = 2'h1;
  localparam logic [1:0] IOH_CMD_CFG = 2'h0;
  localparam logic [5:0] IOH_DEV_MEM_ERR = 6'h01;
  localparam logic [5:0] IOH_DEV_EXT_PIN = 6'h02;
  localparam logic [2:0] IOH_WR_LOW_ZERO = 3'h0;

  // ==========================================================================
  // Types
  typedef enum logic [3:0] {
    IOH_DST_HUB, IOH_DST_CLOCK, IOH_DST_MC0, IOH_DST_MC1, IOH_DST_MC2, IOH_DST_MC3,
    IOH_DST_TEST, IOH_DST_DEBUG, IOH_DST_DMA_CSR, IOH_DST_RESET, IOH_DST_SHARED,
    IOH_DST_BOOT, IOH_DST_PIO, IOH_DST_ERR
  } ioh_dest_e;

  typedef struct packed {
    logic rd;
    logic [7:0] pio_id;
    logic [IOH_MASK_W-1:0] mask;
    logic [IOH_ADDR_W-1:0] addr;
    logic [IOH_DATA_W-1:0] data;
  } ioh_req_s;

  typedef struct packed {
    logic rd;
    logic [IOH_CRED_W-1:0] credit;
    logic [IOH_MASK_W-1:0] mask;
    logic [7:0] pio_id;
    logic [1:0] cmd;
    logic [IOH_BUS_ADDR_W-1:0] bus_addr;
    logic [IOH_DATA_W-1:0] data;
  } ioh_dma_req_s;

  typedef struct packed {
    ioh_dest_e dest;
    ioh_req_s req;
  } ioh_io_req_s;

  typedef struct packed {
    logic [IOH_ID_W-1:0] thread;
    logic [IOH_ID_W-1:0] vector;
  } ioh_route_s;

  typedef struct packed {
    logic mondo;
    ioh_route_s route;
  } ioh_irq_s;

  // ==========================================================================
  // Destination from the upper address byte
  function automatic ioh_dest_e ioh_dest_of(input logic [IOH_ADDR_W-1:0] addr);
    logic [7:0] ub;
    logic [1:0] mc;
    ub = addr[39:32];
    mc = addr[IOH_MC_SEL_LSB+1:IOH_MC_SEL_LSB];
    if (ub == IOH_UB_HUB) return IOH_DST_HUB;
    else if (ub == IOH_UB_CLOCK) return IOH_DST_CLOCK;
    else if (ub == IOH_UB_MEMCTL) return ioh_dest_e'(4'(IOH_DST_MC0) + 4'(mc));
    else if (ub == IOH_UB_TEST) return IOH_DST_TEST;
    else if (ub == IOH_UB_DEBUG) return IOH_DST_DEBUG;
    else if (ub == IOH_UB_DMA_CSR) return IOH_DST_DMA_CSR;
    else if (ub == IOH_UB_RESET) return IOH_DST_RESET;
    else if (ub == IOH_UB_SHARED) return IOH_DST_SHARED;
    else if (ub == IOH_UB_BOOT) return IOH_DST_BOOT;
    else if (ub >= IOH_UB_PIO_LO && ub <= IOH_UB_PIO_HI) return IOH_DST_PIO;
    else return IOH_DST_ERR;
  endfunction

endpackage

// file: rtl/ioh_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module ioh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("ioh_fifo: DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  logic push;
  logic pop;

  assign in_ready = (wr_ptr_ff - rd_ptr_ff) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr_ff != rd_ptr_ff;
  assign out_data = mem[rd_ptr_ff[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push) mem[wr_ptr_ff[AW-1:0]] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (srst) wr_ptr_ff <= '0;
    else if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (srst) rd_ptr_ff <= '0;
    else if (pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
  end
endmodule

// file: rtl/ioh_addr_decode.sv
// Packet decode: destination, command space and outgoing bus address.
// Purely combinational; assumes packets carry address bit 39 set.
`timescale 1ns/1ns
module ioh_addr_decode
  import ioh_pkg::*;
(
  // Packet in
  input wire ioh_req_s req,
  // Decode out
  output ioh_dest_e dest,
  output logic [1:0] cmd,
  output logic [IOH_BUS_ADDR_W-1:0] bus_addr
);
  logic [7:0] ub;

  assign ub = req.addr[39:32];
  assign dest = ioh_dest_of(req.addr);

  // Upper half of the PIO window is 64-bit memory, next quarter 32-bit
  always_comb
  begin
    if (ub[3]) cmd = IOH_CMD_MEM64;
    else if (ub[2]) cmd = IOH_CMD_MEM32;
    else if (req.addr[IOH_IO_SEL_BIT]) cmd = IOH_CMD_IO;
    else cmd = IOH_CMD_CFG;
  end

  // Stores go out doubleword-aligned; the mask keeps the byte positions
  always_comb
  begin
    bus_addr = req.addr[IOH_BUS_ADDR_W-1:0];
    if (!req.rd) bus_addr[2:0] = IOH_WR_LOW_ZERO;
  end
endmodule

// file: sim/ioh_far_model.sv
// Far-side model: PCIe DMA unit, on-chip I/O units and processor threads.
// Assumes the bench seeds $urandom; drives on the falling clock edge.
`timescale 1ns/1ns
module ioh_far_model
  import ioh_pkg::*;
(
  // Clock, reset and control
  input wire logic clk,
  input wire logic srst,
  input wire logic hold_credits,
  // DMA unit and I/O units
  input wire logic dma_valid,
  input wire ioh_dma_req_s dma_req,
  output logic dma_ready,
  output logic credit_ret_valid,
  output logic [IOH_CRED_W-1:0] credit_ret_id,
  output logic io_ready,
  // Processor threads
  input wire logic irq_valid,
  input wire ioh_irq_s irq,
  output logic irq_ready,
  output logic irq_resp_valid,
  output logic irq_resp_ack
);
  logic [IOH_CRED_W-1:0] held[$];
  int resp_wait = -1;
  logic ack_tgl = 1'b1;

  initial
  begin
    dma_ready = 1'b0;
    io_ready = 1'b0;
    irq_ready = 1'b0;
    credit_ret_valid = 1'b0;
    credit_ret_id = '0;
    irq_resp_valid = 1'b0;
    irq_resp_ack = 1'b0;
  end

  always @(posedge clk)
  begin
    if (srst)
      held.delete();
    else if (dma_valid && dma_ready)
      held.push_back(dma_req.credit);
    if (srst)
      resp_wait = -1;
    else if (irq_valid && irq_ready && irq.mondo)
      resp_wait = $urandom_range(0, 3);
  end

  // Ready stalls at random; credits come back in the order they were used
  always @(negedge clk)
  begin
    dma_ready <= 1'($urandom_range(0, 1));
    io_ready <= 1'($urandom_range(0, 1));
    irq_ready <= 1'($urandom_range(0, 1));
    credit_ret_valid <= 1'b0;
    irq_resp_valid <= 1'b0;
    if (!hold_credits && held.size() > 0 && $urandom_range(0, 1) == 1)
    begin
      credit_ret_valid <= 1'b1;
      credit_ret_id <= held.pop_front();
    end
    // Ack and nack alternate so that a swapped answer shows
    if (resp_wait == 0)
    begin
      irq_resp_valid <= 1'b1;
      irq_resp_ack <= ack_tgl;
      ack_tgl <= ~ack_tgl;
    end
    if (resp_wait >= 0)
      resp_wait--;
  end
endmodule

// file: sim/ioh_hub_tb_top.sv
// Self-checking bench for the I/O hub: PIO forwarding, decode, interrupts.
// Assumes ioh_far_model stands at the far side of the DMA, I/O unit and interrupt ports.
`timescale 1ns/1ns
module ioh_hub_tb_top;
  import ioh_pkg::*;
  logic clk = 1'b0, srst = 1'b1, hold = 1'b1;
  logic xbar_valid = 1'b0, mondo_valid = 1'b0, onchip_valid = 1'b0;
  ioh_req_s xbar_req = '0;
  ioh_route_s mondo_route = '0, route_entry = '0;
  logic [5:0] onchip_dev_id = '0;
  logic xbar_ready, dma_valid, dma_ready, credit_ret_valid, io_valid, io_ready, err_valid;
  logic mondo_ready, mondo_ack, mondo_nack, onchip_ready, irq_valid, irq_ready;
  logic irq_resp_valid, irq_resp_ack, a;
  logic [3:0] credit_ret_id;
  logic [7:0] err_pio_id;
  logic [5:0] route_idx;
  ioh_dma_req_s dma_req, exp_d;
  ioh_io_req_s io_req;
  ioh_irq_s irq;
  int failures = 0, num_checks = 0, cycles = 0, dma_cnt = 0;
  bit first_fill = 1'b1;
  logic [15:0] busy = '0;
  ioh_dma_req_s q_dma[$];
  ioh_io_req_s q_io[$];
  logic [7:0] q_err[$];
  ioh_irq_s q_irq[$];
  logic q_ack[$];

  always #50 clk = ~clk;

  ioh_hub #(.FIFO_DEPTH(16)) u_dut (.clk(clk), .srst(srst), .xbar_valid(xbar_valid),
    .xbar_ready(xbar_ready), .xbar_req(xbar_req), .dma_valid(dma_valid),
    .dma_ready(dma_ready), .dma_req(dma_req), .credit_ret_valid(credit_ret_valid),
    .credit_ret_id(credit_ret_id), .io_valid(io_valid), .io_ready(io_ready),
    .io_req(io_req), .err_valid(err_valid), .err_pio_id(err_pio_id),
    .mondo_valid(mondo_valid), .mondo_ready(mondo_ready), .mondo_route(mondo_route),
    .mondo_ack(mondo_ack), .mondo_nack(mondo_nack), .onchip_valid(onchip_valid),
    .onchip_ready(onchip_ready), .onchip_dev_id(onchip_dev_id), .route_idx(route_idx),
    .route_entry(route_entry), .irq_valid(irq_valid), .irq_ready(irq_ready), .irq(irq),
    .irq_resp_valid(irq_resp_valid), .irq_resp_ack(irq_resp_ack));

  ioh_far_model u_far (.clk(clk), .srst(srst), .hold_credits(hold), .dma_valid(dma_valid),
    .dma_req(dma_req), .dma_ready(dma_ready), .credit_ret_valid(credit_ret_valid),
    .credit_ret_id(credit_ret_id), .io_ready(io_ready), .irq_valid(irq_valid), .irq(irq),
    .irq_ready(irq_ready), .irq_resp_valid(irq_resp_valid), .irq_resp_ack(irq_resp_ack));

  // ==========================================================================
  // Reporting
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task check(input logic [127:0] got, input logic [127:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      failures++;
      summarize();
    end
  end

  // ==========================================================================
  // Expectations
  function automatic ioh_dest_e exp_dest(logic [39:0] ad);
    case (ad[39:32])
      8'h80: return IOH_DST_HUB;
      8'h83: return IOH_DST_CLOCK;
      8'h84: return ad[13] ? (ad[12] ? IOH_DST_MC3 : IOH_DST_MC2)
                           : (ad[12] ? IOH_DST_MC1 : IOH_DST_MC0);
      8'h85: return IOH_DST_TEST;
      8'h86: return IOH_DST_DEBUG;
      8'h88: return IOH_DST_DMA_CSR;
      8'h89: return IOH_DST_RESET;
      8'h90: return IOH_DST_SHARED;
      8'hFF: return IOH_DST_BOOT;
      default: return (ad[39:36] == 4'hC) ? IOH_DST_PIO : IOH_DST_ERR;
    endcase
  endfunction

  task automatic enq(input ioh_req_s r);
    ioh_dest_e d;
    ioh_dma_req_s m;
    d = exp_dest(r.addr);
    m = '{r.rd, 4'h0, r.mask, r.pio_id, 2'h0, r.addr[35:0], r.data};
    m.cmd = r.addr[35] ? 2'h3 : r.addr[34] ? 2'h2 : {1'b0, r.addr[28]};
    if (!r.rd)
      m.bus_addr[2:0] = 3'h0;
    if (d == IOH_DST_PIO)
      q_dma.push_back(m);
    else if (d == IOH_DST_ERR)
      q_err.push_back(r.pio_id);
    else
      q_io.push_back(ioh_io_req_s'{dest: d, req: r});
  endtask

  // ==========================================================================
  // Drivers, entered at a falling edge
  task automatic send(input ioh_req_s r, output bit ok);
    int n;
    xbar_req = r;
    xbar_valid = 1'b1;
    n = 0;
    while (!xbar_ready && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    ok = xbar_ready;
    if (ok)
    begin
      enq(r);
      @(negedge clk);
    end
  endtask

  task automatic irq_req(input bit m, input logic [5:0] id, input ioh_route_s rt);
    int n;
    @(negedge clk);
    mondo_route = rt;
    route_entry = rt;
    onchip_dev_id = id;
    mondo_valid = m;
    onchip_valid = !m;
    #1;
    n = 0;
    while (!(m ? mondo_ready : onchip_ready) && n < 300)
    begin
      @(negedge clk);
      #1;
      n++;
    end
    if (!m)
      check(route_idx, id, "route index");
    if (m || id == 6'h01 || id == 6'h02)
      q_irq.push_back(ioh_irq_s'{mondo: m, route: rt});
    @(negedge clk);
    mondo_valid = 1'b0;
    onchip_valid = 1'b0;
  endtask

  function automatic ioh_req_s rnd_req(logic [7:0] ub);
    return '{1'($urandom), 8'($urandom), 8'($urandom), {ub, 32'($urandom)},
      {32'($urandom), 32'($urandom)}};
  endfunction

  // ==========================================================================
  // Monitor
  always @(posedge clk)
    if (!srst)
    begin
      if (credit_ret_valid)
        busy[credit_ret_id] = 1'b0;
      if (dma_valid && dma_ready)
      begin
        check(busy[dma_req.credit], 0, "credit in use");
        if (first_fill)
          check(dma_req.credit, dma_cnt, "credit order");
        busy[dma_req.credit] = 1'b1;
        dma_cnt++;
        exp_d = q_dma.pop_front();
        exp_d.credit = dma_req.credit;
        check(dma_req, exp_d, "dma request");
      end
      if (io_valid && io_ready)
        check(io_req, q_io.pop_front(), "io request");
      if (err_valid)
        check(err_pio_id, q_err.pop_front(), "error id");
      if (irq_valid && irq_ready)
        check(irq, q_irq.pop_front(), "interrupt");
      if (irq_resp_valid)
        q_ack.push_back(irq_resp_ack);
      if (mondo_ack || mondo_nack)
      begin
        a = q_ack.pop_front();
        check({mondo_ack, mondo_nack}, {a, ~a}, "answer order");
      end
    end

  // ==========================================================================
  // Main sequence
  logic [7:0] ex_mask[5] = '{8'h40, 8'h04, 8'h18, 8'h12, 8'h53};
  logic [15:0] ex_lo[5] = '{16'h0001, 16'h0005, 16'h0003, 16'h0003, 16'h0001};
  ioh_req_s r;
  bit ok;
  int sent = 0;

  initial
  begin
    void'($urandom(32'h5569));
    repeat (10) @(negedge clk);
    srst = 1'b0;
    // Credits withheld: sixteen reach the DMA unit, then the FIFO fills
    for (int k = 0; k < 40; k++)
    begin
      r = rnd_req(8'hC8);
      r.rd = 1'b0;
      r.mask = ex_mask[k % 5];
      r.addr[15:0] = ex_lo[k % 5];
      send(r, ok);
      if (!ok)
        break;
      sent++;
    end
    check(sent, 32, "accepted while stalled");
    check(dma_cnt, 16, "outstanding limit");
    xbar_valid = 1'b0;
    first_fill = 1'b0;
    hold = 1'b0;
    @(negedge clk);
    // Every upper byte with bit 39 set, each controller select
    for (int i = 0; i < 512; i++)
    begin
      r = rnd_req(8'h80 | 8'(i[6:0]));
      r.addr[13:12] = 2'(i >> 7);
      r.addr[28] = i[0];
      send(r, ok);
      check(ok, 1'b1, "request refused");
    end
    for (int i = 0; i < 200; i++)
    begin
      r = rnd_req(8'($urandom_range(128, 255)));
      send(r, ok);
      check(ok, 1'b1, "request refused");
    end
    xbar_valid = 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      irq_req(1'b1, 6'h00, ioh_route_s'(12'($urandom)));
      irq_req(1'b0, (i == 6) ? 6'h3F : 6'(i), ioh_route_s'(12'($urandom)));
    end
    for (int n = 0; n < 3000; n++)
      if (q_dma.size() + q_io.size() + q_err.size() + q_irq.size() + q_ack.size() != 0)
        @(negedge clk);
    check(q_dma.size() + q_io.size() + q_err.size() + q_irq.size() + q_ack.size(), 0,
      "undelivered");
    summarize();
  end
endmodule
